// file: src/wsb_pkg.sv
/*
 * Shared constants for the write store buffer: entry layout, cache modes,
 * write sizes, bus sequencer states and control register bit position.
 * Assumes one processor clock domain and no software-visible bus.
 */
package wsb_pkg;
	// Buffer geometry
	localparam int SB_DEPTH = 4;
	localparam int SB_ENTRY_BYTES = 4;
	localparam int SB_MAX_BYTES = 16;
	localparam int SB_CNT_W = 3;
	localparam int SB_ENTRY_W = 66;
	localparam int PAGE_BITS_DEF = 12;

	// Cache mode field encodings
	localparam logic [1:0] CM_WT = 2'h0;
	localparam logic [1:0] CM_CB = 2'h1;
	localparam logic [1:0] CM_PRECISE = 2'h2;
	localparam logic [1:0] CM_IMPRECISE = 2'h3;

	// Write size encodings
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// Store buffer enable position in cache_control_reg, and its reset value
	localparam int CACHE_CONTROL_REG_SBE_BIT = 29;
	localparam logic SBE_RESET = 1'b0;

	// Least stall of an unbuffered write, in cycles
	localparam logic [2:0] DIRECT_MIN_CYC = 3'h5;

	typedef enum logic [1:0] {BS_IDLE, BS_FIFO, BS_DIRECT} wsb_bus_e;
endpackage : wsb_pkg

// file: src/wsb_fifo.sv
/*
 * Entry store for the write buffer: a small first-in first-out array.
 * Assumes the caller never pushes while full nor pops while empty.
 */
`timescale 1ns/1ps
`default_nettype none
module wsb_fifo
	import wsb_pkg::*;
#(
	parameter int WIDTH = SB_ENTRY_W,
	parameter int DEPTH = SB_DEPTH
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic push,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic pop,
	output logic [WIDTH-1:0] out_data,
	output logic full,
	output logic empty,
	output logic [SB_CNT_W-1:0] count
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	localparam logic [SB_CNT_W-1:0] DEPTH_CNT = SB_CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [SB_CNT_W-1:0] cnt_r;
	wire do_push = push && !full;
	wire do_pop = pop && !empty;

	// Status decode
	assign full = (cnt_r == DEPTH_CNT);
	assign empty = (cnt_r == '0);
	assign count = cnt_r;
	assign out_data = mem[rp_r];

	// One storage word per entry
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_ent
			always_ff @(posedge ref_clk) begin
				if (clk_en && do_push && wp_r == PW'(gi))
					mem[gi] <= in_data;
			end
		end
	endgenerate

	// Pointers and occupancy, empty after reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (do_push)
				wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
			if (do_pop)
				rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + SB_CNT_W'(do_push) - SB_CNT_W'(do_pop);
		end
	end

	default clocking cb @(posedge ref_clk iff clk_en); endclocking
	default disable iff (!nrst);

	a_cap_bound: assert property (cnt_r <= DEPTH_CNT) // [RULE_01]
		else $error("store buffer holds more entries than its depth");
	a_full_holds: assert property (full && !pop |=> full && $stable(wp_r)) // [RULE_17]
		else $error("full store buffer accepted an entry");
	a_fifo_order: assert property (do_pop && !do_push |=> rp_r != $past(rp_r)) // [RULE_02]
		else $error("read pointer did not advance on retire");
endmodule : wsb_fifo
`default_nettype wire

// file: src/wsb_store_buffer.sv
/*
 * Write store buffer between the operand pipeline and the bus controller.
 * Splits writes into bus-sized pieces, queues deferrable ones, issues the
 * rest except copyback pieces directly, and holds other bus traffic until buffers are drained.
 * Assumes the pipeline holds its write inputs steady while wr_stall is
 * high, and that the bus controller answers each request with bus_ack.
 * Assumes bus_ack only counts while bus_req is high; clk_en gates all state.
 */
// Behaviour
// RULE_01: Buffer has four entries, sixteen bytes at most.
// RULE_02: Queued writes retire first in first out.
// RULE_03: Buffered writes do not stall; stall only when full with a write pending. A split buffered write stalls one cycle per extra piece.
// RULE_04: Accept one write per cycle; retire at most one per two cycles.
// RULE_05: Unbuffered writes go straight to the bus, stalled at least five cycles.
// RULE_06: Enable bit written by control move; cleared at reset.
// RULE_07: When enabled, writethrough and imprecise pages use the buffer.
// RULE_08: One entry holds up to four bytes and equals one bus cycle.
// RULE_09: Misaligned long makes two entries at odd word, three at odd byte.
// RULE_10: Straddling write buffers only its imprecise part.
// RULE_11: Valid buffer data is issued on the next free bus cycle.
// RULE_12: Other bus transactions wait until push and write buffers are empty.
// RULE_13: Synchronising operations wait until both buffers are drained.
// RULE_14: Writethrough writes always reach memory, buffered or not.
// RULE_15: Precise page accesses keep program order.
// RULE_16: Imprecise writes complete before a missing read goes to the bus.
// RULE_17: Full shown as backpressure; buffer empty after reset.
`timescale 1ns/1ps
`default_nettype none
module wsb_store_buffer
	import wsb_pkg::*;
#(
	parameter int PAGE_BITS = PAGE_BITS_DEF
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic cache_control_reg_wr,
	input wire logic [31:0] cache_control_reg_wdata,
	output logic store_buffer_enable,
	input wire logic wr_valid,
	input wire logic [31:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [1:0] wr_size,
	input wire logic [1:0] wr_mode_lo,
	input wire logic [1:0] wr_mode_hi,
	output logic wr_stall,
	output logic sb_full,
	output logic sb_empty,
	input wire logic push_pending,
	input wire logic other_req,
	output logic other_grant,
	input wire logic sync_req,
	output logic sync_ok,
	output logic bus_req,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_data,
	output logic [1:0] bus_size,
	input wire logic bus_ack
);
	// Byte count of a size code
	function automatic logic [2:0] sz_bytes(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: sz_bytes = 3'h1;
			SZ_WORD: sz_bytes = 3'h2;
			default: sz_bytes = 3'h4;
		endcase
	endfunction

	logic sbe_r;
	logic busy_r;
	logic [31:0] cur_addr_r;
	logic [31:0] cur_data_r;
	logic [2:0] rem_r;
	logic [1:0] piece_cnt_r;
	wsb_bus_e st_r;
	logic req_r;
	logic acked_r;
	logic [2:0] dir_cnt_r;
	logic [31:0] baddr_r;
	logic [31:0] bdata_r;
	logic [1:0] bsize_r;
	logic [SB_ENTRY_W-1:0] head;
	logic [SB_CNT_W-1:0] sb_count;

	// Current piece source: held remainder or fresh write
	wire [31:0] src_addr = busy_r ? cur_addr_r : wr_addr;
	wire [31:0] src_data = busy_r ? cur_data_r : wr_data;
	wire [2:0] src_rem = busy_r ? rem_r : sz_bytes(wr_size);

	// Piece size follows bus alignment: one entry per bus cycle
	wire [1:0] psize = src_addr[0] ? SZ_BYTE : // [RULE_08] [RULE_09]
		src_addr[1] ? ((src_rem >= 3'h2) ? SZ_WORD : SZ_BYTE) :
		(src_rem >= 3'h4) ? SZ_LONG : (src_rem >= 3'h2) ? SZ_WORD : SZ_BYTE;
	wire [2:0] pbytes = sz_bytes(psize);
	wire [31:0] pdata = (psize == SZ_LONG) ? src_data :
		(psize == SZ_WORD) ? {16'h0, src_data[31:16]} : {24'h0, src_data[31:24]};

	// Page mode of this piece; upper page mode once past the boundary
	wire piece_hi = (src_addr[31:PAGE_BITS] != wr_addr[31:PAGE_BITS]); // [RULE_10]
	wire [1:0] pmode = piece_hi ? wr_mode_hi : wr_mode_lo;
	wire piece_buf = sbe_r && (pmode == CM_WT || pmode == CM_IMPRECISE); // [RULE_06] [RULE_07]
	wire piece_cb = (pmode == CM_CB);

	// Drain state shared by direct writes, other traffic and sync
	wire drained = sb_empty && !push_pending && st_r == BS_IDLE; // [RULE_12] [RULE_13]
	wire fifo_push = wr_valid && piece_buf && !sb_full; // [RULE_03] [RULE_17]
	wire fifo_pop = (st_r == BS_IDLE) && !sb_empty; // [RULE_11]
	wire dir_go = wr_valid && !piece_buf && !piece_cb && drained; // [RULE_15]
	// An early termination is remembered until the five cycles are up
	wire ack_seen = (bus_ack && req_r) || acked_r;
	wire dir_done = (st_r == BS_DIRECT) && ack_seen && dir_cnt_r >= DIRECT_MIN_CYC; // [RULE_05]
	wire piece_done = fifo_push || (wr_valid && piece_cb) || dir_done;
	wire last_piece = piece_done && (src_rem == pbytes);

	// Pipeline and drain status
	assign wr_stall = wr_valid && !last_piece; // [RULE_03]
	assign other_grant = other_req && drained; // [RULE_12] [RULE_16]
	assign sync_ok = sync_req && drained; // [RULE_13]
	assign store_buffer_enable = sbe_r;
	assign bus_req = req_r;
	assign bus_addr = baddr_r;
	assign bus_data = bdata_r;
	assign bus_size = bsize_r;

	// Four-entry store, one entry per future bus cycle
	wsb_fifo #(
		.WIDTH(SB_ENTRY_W),
		.DEPTH(SB_DEPTH) // [RULE_01]
	) wsb_fifo_inst (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.push(fifo_push),
		.in_data({psize, src_addr, pdata}),
		.pop(fifo_pop),
		.out_data(head),
		.full(sb_full),
		.empty(sb_empty),
		.count(sb_count)
	);

	// Enable bit, written by the control move
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			sbe_r <= SBE_RESET; // [RULE_06]
		else if (clk_en && cache_control_reg_wr)
			sbe_r <= cache_control_reg_wdata[CACHE_CONTROL_REG_SBE_BIT]; // [RULE_06]
	end

	// Remainder of a split write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			cur_addr_r <= '0;
			cur_data_r <= '0;
			rem_r <= '0;
			piece_cnt_r <= '0;
		end else if (clk_en && piece_done) begin
			// Next piece starts past this one, data moved up to the top
			busy_r <= !last_piece;
			cur_addr_r <= src_addr + {29'h0, pbytes};
			cur_data_r <= src_data << {pbytes, 3'h0};
			rem_r <= src_rem - pbytes;
			piece_cnt_r <= last_piece ? 2'h0 : piece_cnt_r + 2'h1;
		end
	end

	// Bus sequencer: drains the buffer first, then direct writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= BS_IDLE;
			req_r <= 1'b0;
			acked_r <= 1'b0;
			dir_cnt_r <= '0;
			baddr_r <= '0;
			bdata_r <= '0;
			bsize_r <= '0;
		end else if (clk_en) begin
			case (st_r)
				BS_IDLE: begin
					if (fifo_pop) begin // [RULE_02] [RULE_11] [RULE_14]
						{bsize_r, baddr_r, bdata_r} <= head;
						req_r <= 1'b1;
						st_r <= BS_FIFO;
					end else if (dir_go) begin // [RULE_05] [RULE_14]
						{bsize_r, baddr_r, bdata_r} <= {psize, src_addr, pdata};
						req_r <= 1'b1;
						acked_r <= 1'b0;
						dir_cnt_r <= 3'h1;
						st_r <= BS_DIRECT;
					end
				end
				BS_FIFO: begin
					// Dropping the request on termination leaves one idle cycle
					if (bus_ack) begin // [RULE_04]
						req_r <= 1'b0;
						st_r <= BS_IDLE;
					end
				end
				BS_DIRECT: begin
					// Saturate so a slow bus cannot wrap the stall count
					if (dir_cnt_r != 3'h7)
						dir_cnt_r <= dir_cnt_r + 3'h1;
					if (bus_ack && req_r) begin
						req_r <= 1'b0;
						acked_r <= 1'b1;
					end
					if (dir_done) begin
						acked_r <= 1'b0;
						st_r <= BS_IDLE;
					end
				end
				default: begin
					st_r <= BS_IDLE;
					req_r <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge ref_clk iff clk_en); endclocking
	default disable iff (!nrst);

	a_no_stall_buf: assert property ( // [RULE_03]
		wr_valid && !busy_r && piece_buf && !sb_full && src_rem == pbytes |-> !wr_stall)
		else $error("buffered write stalled with room in the buffer");
	a_retire_gap: assert property (req_r && bus_ack |=> !req_r) // [RULE_04]
		else $error("bus request not dropped after termination");
	a_direct_stall: assert property ( // [RULE_05]
		$rose(st_r == BS_DIRECT) |-> $past(wr_stall) ##0 wr_stall [*4])
		else $error("direct write stalled fewer than five cycles");
	a_sbe_follow: assert property (cache_control_reg_wr |=> sbe_r == $past(cache_control_reg_wdata[CACHE_CONTROL_REG_SBE_BIT])) // [RULE_06]
		else $error("enable bit did not follow control move");
	a_buf_only_on: assert property (fifo_push |-> sbe_r && pmode != CM_PRECISE) // [RULE_07]
		else $error("write buffered while disabled or precise");
	a_entry_align: assert property (fifo_push && psize == SZ_LONG |-> src_addr[1:0] == 2'h0) // [RULE_08]
		else $error("long entry is not long-word aligned");
	a_split_word: assert property ( // [RULE_09]
		last_piece && !busy_r == 1'b0 && wr_size == SZ_LONG && wr_addr[1:0] == 2'h2
		|-> piece_cnt_r == 2'h1)
		else $error("odd-word long write did not make two pieces");
	a_split_byte: assert property ( // [RULE_09]
		last_piece && wr_size == SZ_LONG && wr_addr[0] |-> piece_cnt_r == 2'h2)
		else $error("odd-byte long write did not make three pieces");
	a_next_issue: assert property (st_r == BS_IDLE && !sb_empty |=> req_r) // [RULE_11]
		else $error("buffered data not issued on next bus cycle");
	a_other_hold: assert property (other_req && !sb_empty |-> !other_grant) // [RULE_12]
		else $error("other transaction granted before drain");
	a_sync_drain: assert property (sync_ok |-> sb_empty && !push_pending && !req_r) // [RULE_13]
		else $error("sync allowed with writes outstanding");
	a_direct_order: assert property (st_r == BS_DIRECT |-> sb_empty) // [RULE_15]
		else $error("direct write issued ahead of buffered writes");


	// Occupancy and backpressure toward the pipeline
	a_full_stall: assert property ( // [RULE_03] [RULE_17]
		wr_valid && piece_buf && sb_full |-> wr_stall)
		else $error("write taken into a full store buffer");
	a_full_flag: assert property (sb_full |-> sb_count == SB_CNT_W'(SB_DEPTH)) // [RULE_01]
		else $error("full flag does not match the entry count");
	a_entry_bytes: assert property (fifo_push |-> pbytes <= 3'(SB_ENTRY_BYTES)) // [RULE_08]
		else $error("entry wider than one bus cycle");
	a_piece_count: assert property (piece_cnt_r <= 2'h2) // [RULE_09]
		else $error("write split into more than three pieces");
	a_split_page: assert property ( // [RULE_10]
		fifo_push && piece_hi |-> wr_mode_hi == CM_WT || wr_mode_hi == CM_IMPRECISE)
		else $error("precise part of a straddling write was buffered");
	a_cb_bypass: assert property (wr_valid && piece_cb |-> !fifo_push && !dir_go) // [RULE_07]
		else $error("copyback piece sent toward the bus");

	// Bus side: requests stand until terminated, then idle a cycle
	a_req_stable: assert property ( // [RULE_11]
		req_r && !bus_ack |=> req_r && $stable(baddr_r)
			&& $stable(bdata_r) && $stable(bsize_r))
		else $error("bus request changed before termination");
	a_idle_quiet: assert property (st_r == BS_IDLE |-> !req_r) // [RULE_04]
		else $error("bus request left up while sequencer idle");
	a_wt_reach: assert property ( // [RULE_14]
		piece_done && pmode == CM_WT |-> fifo_push || dir_done)
		else $error("writethrough piece finished without a bus cycle");
	a_enable_hold: assert property (!cache_control_reg_wr |=> $stable(sbe_r)) // [RULE_06]
		else $error("enable bit changed without a control move");

	// Unbuffered pieces wait for the drain and for termination
	a_direct_wait: assert property ( // [RULE_15]
		wr_valid && !piece_buf && !piece_cb && st_r != BS_DIRECT && !drained |-> wr_stall)
		else $error("unbuffered write passed pending writes");
	a_ack_needed: assert property ( // [RULE_05]
		wr_valid && st_r == BS_DIRECT && !ack_seen |-> wr_stall)
		else $error("direct write released before bus termination");

	// Other traffic and synchronisation only after the drain
	a_grant_drain: assert property ( // [RULE_12] [RULE_16]
		other_grant |-> sb_empty && !push_pending && st_r == BS_IDLE)
		else $error("other transaction granted with writes pending");
	a_push_first: assert property ( // [RULE_12] [RULE_13]
		push_pending |-> !other_grant && !sync_ok)
		else $error("push buffer data passed by other traffic");
	a_drain_grant: assert property (other_req && drained |-> other_grant) // [RULE_12]
		else $error("drained pipeline kept waiting for its transaction");

	c_split_three: cover property (last_piece && wr_size == SZ_LONG && wr_addr[1:0] == 2'h1);
	c_page_split: cover property (fifo_push && piece_hi);
	c_full_stall: cover property (wr_valid && sb_full && wr_stall);
	c_direct_done: cover property (dir_done);
	c_other_wait: cover property (other_req && !other_grant ##[1:20] other_grant);
endmodule : wsb_store_buffer
`default_nettype wire

// file: verification/wsb_bus_model.sv
/*
 * Bus controller stand-in for the write store buffer: terminates each
 * request after a chosen number of wait cycles.
 * Assumes bus_req is held until the cycle in which bus_ack is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module wsb_bus_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic bus_req,
	input wire logic [7:0] lat,
	output logic bus_ack
);
	logic [7:0] wait_r;

	// Wait cycles of the current request
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wait_r <= 8'h00;
		end else if (bus_req && !bus_ack) begin
			wait_r <= wait_r + 8'h01;
		end else begin
			wait_r <= 8'h00;
		end
	end

	// Terminate only during a request, after lat waits
	assign bus_ack = bus_req && (wait_r >= lat);
endmodule : wsb_bus_model
`default_nettype wire

// file: verification/tb_write_store_buffer.sv
/*
 * Self-checking bench for the write store buffer: table of writes, then
 * fill, drain, sync and mid-run reset cases.
 * Assumes the bus model terminates every request.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_write_store_buffer
	import wsb_pkg::*;
;
	typedef struct {
		logic [31:0] a;
		logic [31:0] d;
		logic [1:0] sz;
		logic [1:0] ml;
		logic [1:0] mh;
		logic [1:0] chk;
	} wsb_row_s;

	logic ref_clk, nrst, clk_en, cache_control_reg_wr, store_buffer_enable, wr_valid, wr_stall;
	logic sb_full, sb_empty, push_pending, other_req, other_grant, sync_req, sync_ok;
	logic bus_req, bus_ack;
	logic acked = 1'b0;
	logic [31:0] cache_control_reg_wdata, wr_addr, wr_data, bus_addr, bus_data, msk;
	logic [1:0] wr_size, wr_mode_lo, wr_mode_hi, bus_size;
	logic [7:0] lat;
	logic [65:0] exp_q[$];
	logic [65:0] got_q[$];
	int fail_count = 0;
	int check_count = 0;
	// Writes: chk 1 = no stall, 2 = direct stall
	wsb_row_s rows[8] = '{
		'{32'h00000100, 32'h11223344, SZ_LONG, CM_WT, CM_WT, 2'h1},
		'{32'h00000105, 32'h55667788, SZ_LONG, CM_WT, CM_WT, 2'h0},
		'{32'h0000010a, 32'h99aabbcc, SZ_LONG, CM_IMPRECISE, CM_IMPRECISE, 2'h0},
		'{32'h00000111, 32'hddee0000, SZ_WORD, CM_IMPRECISE, CM_IMPRECISE, 2'h0},
		'{32'h00000120, 32'hf1000000, SZ_BYTE, CM_WT, CM_WT, 2'h0},
		'{32'h00000130, 32'h12345678, SZ_LONG, CM_CB, CM_CB, 2'h1},
		'{32'h00002ffe, 32'h9abcdef0, SZ_LONG, CM_PRECISE, CM_IMPRECISE, 2'h0},
		'{32'h00000140, 32'h0badcafe, SZ_LONG, CM_PRECISE, CM_PRECISE, 2'h2}
	};

	wsb_store_buffer wsb_store_buffer_inst (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
		.cache_control_reg_wr(cache_control_reg_wr), .cache_control_reg_wdata(cache_control_reg_wdata), .store_buffer_enable(store_buffer_enable),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_size(wr_size),
		.wr_mode_lo(wr_mode_lo), .wr_mode_hi(wr_mode_hi), .wr_stall(wr_stall),
		.sb_full(sb_full), .sb_empty(sb_empty), .push_pending(push_pending),
		.other_req(other_req), .other_grant(other_grant), .sync_req(sync_req),
		.sync_ok(sync_ok), .bus_req(bus_req), .bus_addr(bus_addr), .bus_data(bus_data),
		.bus_size(bus_size), .bus_ack(bus_ack));
	wsb_bus_model wsb_bus_model_inst (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req),
		.lat(lat), .bus_ack(bus_ack));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic chk_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s", $time, what);
		end
	endtask : chk_bit

	task automatic chk_cyc(input logic [65:0] got, input logic [65:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t bus cycle %h, expected %h", $time, got, exp);
		end
	endtask : chk_cyc

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick

	// Expected bus pieces of one write, copyback pieces dropped
	function automatic void expect_w(input wsb_row_s r);
		logic [31:0] a;
		logic [31:0] d;
		int n;
		int k;
		a = r.a;
		d = r.d;
		n = (r.sz == SZ_LONG) ? 4 : (r.sz == SZ_WORD) ? 2 : 1;
		while (n > 0) begin
			k = a[0] ? 1 : a[1] ? ((n >= 2) ? 2 : 1) : ((n >= 4) ? 4 : (n >= 2) ? 2 : 1);
			if (((a[31:12] != r.a[31:12]) ? r.mh : r.ml) != CM_CB) begin
				exp_q.push_back({a, d >> (32 - 8 * k), (k == 4) ? SZ_LONG : (k == 2) ? SZ_WORD : SZ_BYTE});
			end
			d = d << (8 * k);
			a = a + 32'(k);
			n = n - k;
		end
	endfunction : expect_w

	// One write, held until taken; returns its stall cycles
	task automatic wr(input wsb_row_s r, output int st);
		wr_valid = 1'b1;
		wr_addr = r.a;
		wr_data = r.d;
		wr_size = r.sz;
		wr_mode_lo = r.ml;
		wr_mode_hi = r.mh;
		st = 0;
		expect_w(r);
		@(negedge ref_clk);
		while (wr_stall !== 1'b0 && st < 300) begin
			st++;
			@(negedge ref_clk);
		end
		if (st >= 300) begin
			fail_count++;
			test_done();
		end
		tick();
	endtask : wr

	// Bus cycle log; no request right after a termination
	assign msk = (bus_size == SZ_LONG) ? 32'hffffffff : (bus_size == SZ_WORD) ? 32'h0000ffff : 32'h000000ff;
	always @(posedge ref_clk) begin
		if (acked) chk_bit(bus_req, 1'b0, "no gap after ack");
		acked = nrst === 1'b1 && bus_req === 1'b1 && bus_ack === 1'b1;
		if (acked) got_q.push_back({bus_addr, bus_data & msk, bus_size});
	end

	initial begin
		int st;
		{nrst, cache_control_reg_wr, wr_valid, push_pending, other_req, sync_req} = 6'h00;
		clk_en = 1'b1;
		{cache_control_reg_wdata, wr_addr, wr_data, wr_size, wr_mode_lo, wr_mode_hi} = 102'h0;
		lat = 8'h00;
		repeat (16) tick();
		nrst = 1'b1;
		chk_bit(sb_empty, 1'b1, "not empty after reset");
		chk_bit(sb_full | bus_req | store_buffer_enable, 1'b0, "reset state");
		wr('{32'h00000200, 32'hcafef00d, SZ_LONG, CM_WT, CM_WT, 2'h2}, st);
		chk_bit(st >= DIRECT_MIN_CYC, 1'b1, "disabled write short stall");
		wr_valid = 1'b0;
		cache_control_reg_wr = 1'b1;
		cache_control_reg_wdata = 32'h20000000;
		tick();
		cache_control_reg_wr = 1'b0;
		chk_bit(store_buffer_enable, 1'b1, "enable not set");
		// Frozen clock enable: a control move must not land
		clk_en = 1'b0;
		cache_control_reg_wr = 1'b1;
		cache_control_reg_wdata = 32'h00000000;
		repeat (2) tick();
		cache_control_reg_wr = 1'b0;
		clk_en = 1'b1;
		chk_bit(store_buffer_enable, 1'b1, "enable changed while frozen");
		foreach (rows[i]) begin
			wr(rows[i], st);
			if (rows[i].chk == 2'h1) chk_bit(st == 0, 1'b1, "buffered stall");
			if (rows[i].chk == 2'h2) chk_bit(st >= DIRECT_MIN_CYC, 1'b1, "direct short");
		end
		// Fill against a slow bus with another transaction waiting
		lat = 8'h1e;
		other_req = 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr('{32'h00000300 + 32'(4 * i), 32'h01020304, SZ_LONG, CM_WT, CM_WT, 2'h1}, st);
			chk_bit(st == 0, 1'b1, "fill stalled");
			if (i == 1) chk_bit(bus_req, 1'b1, "bus idle with data");
		end
		chk_bit(sb_full, 1'b1, "not full");
		chk_bit(other_grant, 1'b0, "grant while buffered");
		wr('{32'h00000314, 32'h05060708, SZ_LONG, CM_IMPRECISE, CM_IMPRECISE, 2'h0}, st);
		chk_bit(st > 0, 1'b1, "full did not stall");
		wr_valid = 1'b0;
		push_pending = 1'b1;
		sync_req = 1'b1;
		st = 0;
		while (!(sb_empty === 1'b1 && bus_req === 1'b0) && st < 1000) begin
			tick();
			st++;
		end
		if (st >= 1000) begin
			fail_count++;
			test_done();
		end
		tick();
		chk_bit(sync_ok | other_grant, 1'b0, "passed push data");
		push_pending = 1'b0;
		#1;
		chk_bit(sync_ok & other_grant, 1'b1, "drained, no grant");
		{other_req, sync_req} = 2'h0;
		chk_bit(got_q.size() == exp_q.size(), 1'b1, "bus cycle count");
		foreach (exp_q[i]) begin
			if (i < got_q.size()) chk_cyc(got_q[i], exp_q[i]);
		end
		// Reset with a buffered write out on the bus
		wr('{32'h00000400, 32'h0a0b0c0d, SZ_LONG, CM_WT, CM_WT, 2'h1}, st);
		wr_valid = 1'b0;
		tick();
		nrst = 1'b0;
		#1;
		chk_bit(sb_empty, 1'b1, "mid-run reset");
		chk_bit(bus_req | store_buffer_enable, 1'b0, "mid-run reset");
		// Release again: enable cleared, so a writethrough write goes direct
		exp_q.delete();
		got_q.delete();
		lat = 8'h00;
		repeat (2) tick();
		nrst = 1'b1;
		wr('{32'h00000500, 32'h13572468, SZ_LONG, CM_WT, CM_WT, 2'h2}, st);
		wr_valid = 1'b0;
		chk_bit(st >= DIRECT_MIN_CYC, 1'b1, "write buffered after reset");
		chk_bit(got_q.size() == 1, 1'b1, "post-reset bus cycle count");
		if (got_q.size() == 1) chk_cyc(got_q[0], exp_q[0]);
		test_done();
	end
endmodule : tb_write_store_buffer
`default_nettype wire
